/* pbsr_read_path.sv */
// Purpose: synchronous burst SRAM access path with double-cycle deselect
// Assumes: bus inputs are synchronous to clock_in; oe, strap and test pins are not
// Notes: writes queue in a 16-word FIFO and drain when the array is not read
`timescale 1ns/1ps
module pbsr_read_path (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [pbsr_pkg::ADDR_W-1:0] addr_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_enable_n_in,
    input wire logic [pbsr_pkg::LANES-1:0] byte_write_select_n_in,
    input wire logic chip_sel_first_n_in,
    input wire logic chip_sel_second_in,
    input wire logic chip_sel_third_n_in,
    input wire logic out_enable_n_in,
    input wire logic burst_mode_in,
    input wire logic [pbsr_pkg::DATA_W-1:0] dq_in,
    output logic [pbsr_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n_out,
    input wire logic test_clock_in,
    input wire logic test_data_in,
    input wire logic test_mode_sel_in,
    output logic test_data_out,
    output logic write_full_out
);
    import pbsr_pkg::*;

    // ========================================
    // input registers
    logic [ADDR_W-1:0] addr_reg;
    logic pstb_n_reg;
    logic cstb_n_reg;
    logic advance_n_reg;
    logic gwr_n_reg;
    logic bwr_n_reg;
    logic [LANES-1:0] lane_n_reg;
    logic cs1_n_reg;
    logic cs2_reg;
    logic cs3_n_reg;
    logic [DATA_W-1:0] dq_reg;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_reg <= '0;
            pstb_n_reg <= '1;
            cstb_n_reg <= '1;
            advance_n_reg <= '1;
            gwr_n_reg <= '1;
            bwr_n_reg <= '1;
            lane_n_reg <= '1;
            cs1_n_reg <= '1;
            cs2_reg <= '0;
            cs3_n_reg <= '1;
            dq_reg <= '0;
        end else begin
            addr_reg <= addr_in; // R6
            pstb_n_reg <= proc_addr_strobe_n_in;
            cstb_n_reg <= ctrl_addr_strobe_n_in;
            advance_n_reg <= burst_advance_n_in;
            gwr_n_reg <= global_write_n_in;
            bwr_n_reg <= byte_write_enable_n_in;
            lane_n_reg <= byte_write_select_n_in;
            cs1_n_reg <= chip_sel_first_n_in;
            cs2_reg <= chip_sel_second_in;
            cs3_n_reg <= chip_sel_third_n_in;
            dq_reg <= dq_in;
        end
    end

    // ========================================
    // pin synchronisers: a level counts once stages two and three agree
    logic [SYNC_CH-1:0] async_pins;
    logic [SYNC_CH-1:0] sync1_reg;
    logic [SYNC_CH-1:0] sync2_reg;
    logic [SYNC_CH-1:0] sync3_reg;
    logic [SYNC_CH-1:0] filt_reg;
    assign async_pins = {test_mode_sel_in, test_data_in, test_clock_in, burst_mode_in, out_enable_n_in};

    for (genvar g = 0; g < SYNC_CH; g++) begin : g_sync
        always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
                sync1_reg[g] <= SYNC_RST[g];
                sync2_reg[g] <= SYNC_RST[g];
                sync3_reg[g] <= SYNC_RST[g];
                filt_reg[g] <= SYNC_RST[g];
            end else begin
                sync1_reg[g] <= async_pins[g];
                sync2_reg[g] <= sync1_reg[g];
                sync3_reg[g] <= sync2_reg[g];
                if (sync2_reg[g] == sync3_reg[g]) begin
                    filt_reg[g] <= sync3_reg[g];
                end
            end
        end
    end

    logic oe_low;
    logic strap_linear;
    assign oe_low = !filt_reg[CH_OE];
    assign strap_linear = (filt_reg[CH_MODE] == MODE_LINEAR); // R1 R2

    // ========================================
    // access decode
    pbsr_sel_type sel_state;
    logic sel_active;
    logic sel_ok;
    logic pstb_take;
    logic cstb_take;
    logic strobe;
    logic active_now;
    logic wr_any;
    logic write_now;
    logic read_now;
    logic [LANES-1:0] lane_mask;

    always_comb begin
        unique case (sel_state)
            SEL_IDLE: sel_active = 1'b0;
            SEL_ACTIVE: sel_active = 1'b1;
            default: sel_active = 1'b0;
        endcase
    end

    assign sel_ok = !cs1_n_reg && cs2_reg && !cs3_n_reg; // R22
    assign pstb_take = !pstb_n_reg && !cs1_n_reg; // R10
    assign cstb_take = !cstb_n_reg && !pstb_take; // R18
    assign strobe = pstb_take || cstb_take;
    assign active_now = strobe ? sel_ok : sel_active;
    assign wr_any = !gwr_n_reg || !bwr_n_reg;
    // a processor-strobe start never writes in its first cycle, and reads only with both write inputs high
    assign write_now = active_now && wr_any && !pstb_take;
    assign read_now = active_now && !wr_any; // R11 R16
    // global write wins over the byte selects
    assign lane_mask = !gwr_n_reg ? ALL_LANES : (!bwr_n_reg ? ~lane_n_reg : NO_LANES); // R8 R9

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel_state <= SEL_IDLE;
        end else if (strobe) begin
            sel_state <= sel_ok ? SEL_ACTIVE : SEL_IDLE; // R11
        end
    end

    // ========================================
    // burst counter
    logic [ADDR_W-1:0] line_reg;
    logic [BURST_W-1:0] base_reg;
    logic [BURST_W-1:0] step_reg;
    logic [BURST_W-1:0] step_next;
    logic [BURST_W-1:0] cur_low;
    logic [MEM_AW-1:0] idx_now;

    function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] step,
                                                     input logic linear);
        burst_low = linear ? base + step : base ^ step;
    endfunction

    assign step_next = (!strobe && sel_active && !advance_n_reg) ? step_reg + STEP_ONE : step_reg; // R20 R7
    assign cur_low = burst_low(base_reg, step_next, strap_linear); // R1 R2
    // a starting access reads the array at the presented address
    assign idx_now = strobe ? addr_reg[MEM_AW-1:0] : {line_reg[MEM_AW-1:BURST_W], cur_low}; // R12

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            line_reg <= '0;
            base_reg <= STEP_ZERO;
            step_reg <= STEP_ZERO;
        end else if (strobe) begin
            line_reg <= addr_reg; // R12
            base_reg <= addr_reg[BURST_W-1:0]; // R19
            step_reg <= STEP_ZERO;
        end else begin
            step_reg <= step_next; // R7
        end
    end

    // ========================================
    // write queue and array
    pbsr_fifo_if #(.WIDTH(WR_W)) wr_q ();
    logic [DATA_W-1:0] rdata;
    logic [MEM_AW-1:0] drain_idx;
    logic [DATA_W-1:0] drain_data;
    logic [LANES-1:0] drain_mask;
    logic drain;

    assign wr_q.in_valid = write_now;
    assign wr_q.in_data = {idx_now, dq_reg, lane_mask};
    // reads own the array port, so a read stream stalls the drain
    assign wr_q.out_ready = !read_now;
    assign {drain_idx, drain_data, drain_mask} = wr_q.out_data;
    assign drain = wr_q.out_valid && !read_now;

    pbsr_fifo #(.WIDTH(WR_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .q(wr_q.store)
    );

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem_reg [MEM_DEPTH];
        always_ff @(posedge clock_in) begin
            if (drain && drain_mask[g]) begin
                mem_reg[drain_idx] <= drain_data[g*LANE_W +: LANE_W]; // R8 R9
            end
        end
        assign rdata[g*LANE_W +: LANE_W] = mem_reg[idx_now];
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            write_full_out <= 1'b0;
        end else begin
            write_full_out <= !wr_q.in_ready;
        end
    end

    // ========================================
    // output register and drive control
    logic data_ok_reg;
    logic data_ok_next;
    logic desel_edge;

    assign desel_edge = sel_active && strobe && !sel_ok;
    // coming out of deselect the previous cycle held no data, so the bus floats
    // for the first access cycle; on deselect the last word is kept one cycle
    assign data_ok_next = read_now || (desel_edge && data_ok_reg); // R14 R17

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dq_out <= '0;
            data_ok_reg <= 1'b0;
            dq_oe_n_out <= 1'b1;
        end else begin
            if (read_now) begin
                dq_out <= rdata; // R13 R6
            end
            data_ok_reg <= data_ok_next;
            dq_oe_n_out <= !(data_ok_next && oe_low); // R15 R21
        end
    end

    // ========================================
    // boundary-scan pins: bypass path
    logic tck_prev_reg;
    logic tck_rise;
    logic tck_fall;
    logic bypass_reg;
    logic tms_reg;
    assign tck_rise = filt_reg[CH_TCK] && !tck_prev_reg;
    assign tck_fall = !filt_reg[CH_TCK] && tck_prev_reg;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tck_prev_reg <= 1'b0;
            bypass_reg <= 1'b0;
            tms_reg <= 1'b0;
            test_data_out <= 1'b0;
        end else begin
            tck_prev_reg <= filt_reg[CH_TCK];
            if (tck_rise) begin
                tms_reg <= filt_reg[CH_TMS]; // R5
                if (!filt_reg[CH_TMS]) begin
                    bypass_reg <= filt_reg[CH_TDI]; // R5
                end
            end
            if (tck_fall && !tms_reg) begin
                test_data_out <= bypass_reg; // R4
            end
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    a_strobe_gate_first: assert property ( // R10
        (!pstb_n_reg && cs1_n_reg && cstb_n_reg) |=> sel_state == $past(sel_state))
        else $error("processor strobe acted with first enable high");
    a_proc_strobe_wins: assert property ( // R18
        (pstb_take && !cstb_n_reg) |=> line_reg == $past(addr_reg) && step_reg == STEP_ZERO)
        else $error("processor strobe not taken when both strobes low");
    a_read_start_sel: assert property ( // R11
        (strobe && sel_ok && gwr_n_reg && bwr_n_reg) |=> sel_state == SEL_ACTIVE && data_ok_reg)
        else $error("read start did not select the device");
    a_counter_load: assert property ( // R19
        strobe |=> base_reg == $past(addr_reg[BURST_W-1:0]) && step_reg == STEP_ZERO)
        else $error("burst counter not loaded from address");
    a_burst_advance: assert property ( // R20
        (!strobe && sel_active && !advance_n_reg) |=> step_reg == $past(step_reg) + STEP_ONE)
        else $error("burst counter did not advance");
    a_burst_hold: assert property ( // R7
        (!strobe && advance_n_reg) |=> $stable(step_reg))
        else $error("burst counter moved without advance");
    a_linear_order: assert property ( // R1
        strap_linear |-> BURST_W'(cur_low - base_reg) == step_next)
        else $error("linear burst order broken");
    a_interleave_order: assert property ( // R2
        !strap_linear |-> (cur_low ^ base_reg) == step_next)
        else $error("interleaved burst order broken");
    a_read_data_out: assert property ( // R13
        (read_now && oe_low) |=> dq_out == $past(rdata) && !dq_oe_n_out)
        else $error("read data not driven after the rise");
    a_first_cycle_float: assert property ( // R14
        (sel_state == SEL_IDLE && $past(sel_state) == SEL_IDLE) |-> dq_oe_n_out)
        else $error("bus driven while deselected");
    a_dcd_extra_cycle: assert property ( // R17
        (desel_edge && data_ok_reg && oe_low) |=> !dq_oe_n_out && dq_out == $past(dq_out))
        else $error("outputs dropped at deselect instead of a cycle later");
    a_oe_high_float: assert property ( // R21
        !oe_low |=> dq_oe_n_out)
        else $error("bus driven with output enable high");
    a_write_lanes: assert property ( // R9
        (write_now && !gwr_n_reg) |-> wr_q.in_data[LANES-1:0] == ALL_LANES)
        else $error("global write did not select every lane");
    a_byte_gate: assert property ( // R8
        (write_now && gwr_n_reg && bwr_n_reg) |-> wr_q.in_data[LANES-1:0] == NO_LANES)
        else $error("byte written without byte-write enable");
    a_tdo_on_fall: assert property ( // R4
        !tck_fall |=> $stable(test_data_out))
        else $error("serial output changed off a falling test clock");
    a_tdi_on_rise: assert property ( // R5
        !tck_rise |=> $stable(bypass_reg) && $stable(tms_reg))
        else $error("serial input sampled off a rising test clock");

    c_read_burst: cover property (read_now && !strobe && !advance_n_reg);
    c_back_to_back: cover property (read_now && strobe ##1 read_now && strobe);
    c_deselect_hold: cover property (desel_edge && data_ok_reg ##1 !dq_oe_n_out ##1 dq_oe_n_out);
    c_queue_full: cover property (write_full_out);
endmodule

/* pbsr_pkg.sv */
// Purpose: shared constants and types of the pipelined burst SRAM access path
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes: the array model keeps MEM_AW address bits of the word address
//
// Operation
// R1: strap low selects linear burst order
// R2: strap high or open selects interleaved order; strap pulls up
// R3: system keeps the burst-order strap static while operating
// R4: boundary-scan serial output changes on the test clock falling edge
// R5: boundary-scan serial and mode inputs are sampled on the test clock rise
// R6: synchronous inputs and data outputs pass registers on the main clock rise
// R7: two-bit wrapping counter holds burst start and advances only when told
// R8: byte lanes are written only with byte-write enable and their select
// R9: global write overrides byte writes and writes every lane
// R10: processor strobe is ignored while first chip enable is high
// R11: read starts on a strobe, full select, and both write enables high
// R12: read start loads address register and burst logic and reads the array
// R13: read data drives the bus after the following rise when enabled
// R14: leaving deselect, outputs float for the first access cycle
// R15: after the first cycle, output enable alone decides drive or float
// R16: back-to-back single reads run in consecutive cycles
// R17: after a deselect, outputs drive one more cycle then float
// R18: with both strobes low only the processor strobe counts
// R19: a captured address loads its two low bits into the counter
// R20: advance low at a rise steps the counter within the burst
// R21: data pins drive only while output enable is low
// R22: selected only with first and third enables low, second high
package pbsr_pkg;
    localparam int ADDR_W = 18;
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int WR_W = MEM_AW + DATA_W + LANES;
    localparam int SYNC_CH = 5;
    localparam int CH_OE = 0;
    localparam int CH_MODE = 1;
    localparam int CH_TCK = 2;
    localparam int CH_TDI = 3;
    localparam int CH_TMS = 4;
    // reset levels: output enable high, strap high, test pins low
    localparam logic [SYNC_CH-1:0] SYNC_RST = 5'h03;
    localparam logic MODE_LINEAR = 1'b0;
    localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [LANES-1:0] NO_LANES = 4'h0;
    typedef enum logic [1:0] {
        SEL_IDLE = 2'b01,
        SEL_ACTIVE = 2'b10
    } pbsr_sel_type;
endpackage

/* pbsr_fifo_if.sv */
// Purpose: valid/ready carrier between the access path and its write queue
// Assumes: both ends on the same clock
// Notes: store modport is the queue side
`timescale 1ns/1ps
interface pbsr_fifo_if #(parameter int WIDTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport store (input in_valid, output in_ready, input in_data,
                   output out_valid, input out_ready, output out_data);
    modport user (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
endinterface

/* pbsr_fifo.sv */
// Purpose: flip-flop queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: push is refused while full, pop while empty
`timescale 1ns/1ps
module pbsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    pbsr_fifo_if.store q
);
    import pbsr_pkg::*;
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW:0] wptr_reg;
    logic [PW:0] rptr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wptr_reg == rptr_reg);
    assign full = (wptr_reg[PW-1:0] == rptr_reg[PW-1:0]) && (wptr_reg[PW] != rptr_reg[PW]);
    assign push = q.in_valid && !full;
    assign pop = q.out_ready && !empty;
    assign q.in_ready = !full;
    assign q.out_valid = !empty;
    assign q.out_data = mem_reg[rptr_reg[PW-1:0]];

    // ========================================
    // pointers
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end

    // ========================================
    // storage
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_reg[wptr_reg[PW-1:0]] <= q.in_data;
        end
    end
endmodule

/* pbsr_cpu_model.sv */
// Purpose: bus-side model of the processor or cache controller
// Assumes: cyc waits for a clock rise and changes pins 5 ns later
// Notes: ctl packs chip selects [11:9], strobes [8:7], advance [6], global write [5], byte write [4], lanes [3:0]
`timescale 1ns/1ps
module pbsr_cpu_model (
    input wire logic clock_in,
    output logic [pbsr_pkg::ADDR_W-1:0] addr_out,
    output logic [11:0] ctl_out,
    output logic [pbsr_pkg::DATA_W-1:0] dq_out,
    output logic strap_out
);
    import pbsr_pkg::*;
    logic [DATA_W-1:0] last_reg;
    initial begin
        addr_out = '0;
        ctl_out = 12'hd7f;
        dq_out = '0;
        last_reg = '0;
        strap_out = 1'b1;
    end
    // ==========================================================
    // strap
    // only called while the device is held in reset
    task automatic set_strap(input logic m);
        strap_out = m;
    endtask
    // ==========================================================
    // bus cycle
    task automatic cyc(input logic [11:0] c, input int a, input logic [DATA_W-1:0] d);
        @(posedge clock_in);
        #5;
        addr_out = ADDR_W'(a);
        ctl_out = c;
        if (!c[5] || !c[4]) begin
            dq_out = d;
            last_reg = d;
        end else begin
            // released data lines toggle so no stale value passes for data
            dq_out = ~last_reg;
            last_reg = ~last_reg;
        end
    endtask
endmodule

/* pbsr_read_path_tb.sv */
// Purpose: self-checking bench for the burst SRAM access path
// Assumes: all pins change 5 ns after a clock rise
// Notes: after a bus step the outputs show the decode of pins from two steps earlier
`timescale 1ns/1ps
module pbsr_read_path_tb;
    import pbsr_pkg::*;
    localparam logic [11:0] IDLE = 12'hd7f;
    localparam logic [11:0] RD = 12'h57f;
    localparam logic [11:0] STEPS = 12'h5bf;
    localparam logic [11:0] HOLD = 12'h5ff;
    localparam logic [11:0] WRG = 12'h55f;
    localparam logic [11:0] WRB0 = 12'h56e;
    localparam logic [11:0] WRBN = 12'h56f;
    localparam logic [11:0] WRGB = 12'h54f;
    localparam logic [11:0] BOTHW = 12'h45f;
    localparam logic [11:0] PNOCE = 12'hcff;
    localparam logic [11:0] DSEL [3] = '{12'hd7f, 12'h17f, 12'h77f};
    logic clock_in, nrst_in, out_enable_n_in, test_clock_in, test_data_in, test_mode_sel_in;
    logic strap, dq_oe_n_out, test_data_out, write_full_out;
    logic [ADDR_W-1:0] addr;
    logic [11:0] ctl;
    logic [DATA_W-1:0] cpu_dq, dq_out, dq_bus;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    int mismatches, n_tests;
    assign dq_bus = dq_oe_n_out ? cpu_dq : dq_out;
    pbsr_cpu_model cpu (.clock_in(clock_in), .addr_out(addr), .ctl_out(ctl), .dq_out(cpu_dq), .strap_out(strap));
    pbsr_read_path DUT (
        .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr),
        .proc_addr_strobe_n_in(ctl[8]), .ctrl_addr_strobe_n_in(ctl[7]),
        .burst_advance_n_in(ctl[6]), .global_write_n_in(ctl[5]),
        .byte_write_enable_n_in(ctl[4]), .byte_write_select_n_in(ctl[3:0]),
        .chip_sel_first_n_in(ctl[11]), .chip_sel_second_in(ctl[10]), .chip_sel_third_n_in(ctl[9]),
        .out_enable_n_in(out_enable_n_in), .burst_mode_in(strap), .dq_in(dq_bus), .dq_out(dq_out),
        .dq_oe_n_out(dq_oe_n_out), .test_clock_in(test_clock_in), .test_data_in(test_data_in),
        .test_mode_sel_in(test_mode_sel_in), .test_data_out(test_data_out), .write_full_out(write_full_out)
    );
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    // ==========================================================
    // helpers
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) cpu.cyc(IDLE, 0, '0);
    endtask
    task automatic do_reset(input logic m);
        nrst_in = 1'b0;
        cpu.set_strap(m);
        repeat (2) @(posedge clock_in);
        #5;
        nrst_in = 1'b1;
        idle(8);
    endtask
    task automatic rd_check(input int a);
        cpu.cyc(RD, a, '0);
        idle(2);
        check(dq_out, mem[a]);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_fill;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] = 36'h9a5a50000 | DATA_W'(i * 17);
            cpu.cyc(WRG, i, mem[i]);
        end
        idle(3);
        check(DATA_W'(write_full_out), 36'h0);
        $display("fill done");
    endtask
    task automatic t_reads;
        cpu.cyc(RD, 0, '0);
        cpu.cyc(RD, 1, '0);
        check(DATA_W'(dq_oe_n_out), 36'h1);
        for (int i = 2; i < 6; i++) begin
            cpu.cyc(i < 4 ? RD : IDLE, i, '0);
            check(dq_out, mem[i-2]);
        end
        check(DATA_W'(dq_oe_n_out), 36'h0);
        idle(3);
        $display("reads done");
    endtask
    task automatic t_bytes;
        logic [DATA_W-1:0] q;
        q = ~mem[8];
        cpu.cyc(WRB0, 8, q);
        cpu.cyc(WRBN, 8, ~q);
        cpu.cyc(WRGB, 9, q);
        mem[8][LANE_W-1:0] = q[LANE_W-1:0];
        mem[9] = q;
        idle(3);
        rd_check(8);
        rd_check(9);
        idle(2);
        $display("byte writes done");
    endtask
    task automatic t_strobes;
        cpu.cyc(RD, 3, '0);
        cpu.cyc(PNOCE, 3, '0);
        idle(3);
        check(DATA_W'(dq_oe_n_out), 36'h0);
        check(dq_out, mem[3]);
        cpu.cyc(BOTHW, 10, ~mem[10]);
        idle(3);
        rd_check(10);
        idle(2);
        $display("strobes done");
    endtask
    task automatic t_deselect;
        for (int k = 0; k < 3; k++) begin
            cpu.cyc(RD, k + 11, '0);
            cpu.cyc(DSEL[k], 0, '0);
            idle(1);
            check(dq_out, mem[k+11]);
            idle(1);
            check(DATA_W'(dq_oe_n_out), 36'h0);
            idle(1);
            check(DATA_W'(dq_oe_n_out), 36'h1);
        end
        $display("deselect done");
    endtask
    task automatic t_oe;
        cpu.cyc(RD, 2, '0);
        out_enable_n_in = 1'b1;
        repeat (7) cpu.cyc(HOLD, 2, '0);
        check(DATA_W'(dq_oe_n_out), 36'h1);
        out_enable_n_in = 1'b0;
        repeat (7) cpu.cyc(HOLD, 2, '0);
        check(DATA_W'(dq_oe_n_out), 36'h0);
        check(dq_out, mem[2]);
        idle(3);
        $display("output enable done");
    endtask
    task automatic t_test_port;
        logic b;
        for (int i = 0; i < 2; i++) begin
            b = (i == 0);
            test_data_in = b;
            test_clock_in = 1'b1;
            idle(8);
            check(DATA_W'(test_data_out), DATA_W'(!b));
            test_data_in = ~b;
            test_clock_in = 1'b0;
            idle(8);
            check(DATA_W'(test_data_out), DATA_W'(b));
        end
        // mode select high: the serial input is not taken and the output holds
        test_mode_sel_in = 1'b1;
        test_clock_in = 1'b1;
        idle(8);
        test_clock_in = 1'b0;
        idle(8);
        check(DATA_W'(test_data_out), 36'h0);
        test_mode_sel_in = 1'b0;
        $display("test port done");
    endtask
    task automatic t_burst(input logic m);
        int st;
        logic [MEM_AW-1:0] a;
        do_reset(m);
        cpu.cyc(RD, 5, '0);
        for (int s = 1; s < 7; s++) begin
            cpu.cyc(s < 4 ? STEPS : (s == 4 ? HOLD : IDLE), 5, '0);
            if (s >= 2) begin
                st = (s > 5) ? 3 : s - 2;
                a = m ? MEM_AW'(4 | (1 ^ st)) : MEM_AW'(4 | ((1 + st) & 3));
                check(dq_out, mem[a]);
            end
        end
        idle(2);
        $display("burst mode %0d done", m);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        mismatches = 0;
        n_tests = 0;
        nrst_in = 1'b0;
        out_enable_n_in = 1'b0;
        test_clock_in = 1'b0;
        test_data_in = 1'b0;
        test_mode_sel_in = 1'b0;
        do_reset(1'b1);
        t_fill;
        t_reads;
        t_bytes;
        t_strobes;
        t_deselect;
        t_oe;
        t_test_port;
        t_burst(1'b0);
        t_burst(1'b1);
        complete_run;
    end
    initial begin
        #(3000 * 50);
        mismatches++;
        complete_run;
    end
endmodule
